// >>> design/vpw_byte_decoder_dma.sv
// DMA interface of the VPW byte decoder: register page and DMA sequencer.
// Assumes the on-chip DMA controller does the memory moves and reports each
// operation with dmaAck; acknowledge timing follows its own priority rules.
`timescale 1ns/1ps
`default_nettype none
module vpw_byte_decoder_dma
    import vpw_dma_pkg::*;
(
    input  wire logic                   clk,        // 50 MHz core clock
    input  wire logic                   rst_n,      // Async reset, active low
    input  wire logic [7:0]             regPage,    // Current register page
    input  wire vpw_dma_pkg::reg_req_s  regReq,     // Register port request
    output logic [7:0]                  regRdata,   // Read data, cycle after
    input  wire logic                   rxByteIn,   // Decoder has a new byte
    input  wire logic [7:0]             rxByte,     // Received byte
    input  wire logic                   txAccept,   // Transmitter took opcode
    input  wire logic                   errorFlag,  // Any error bit set
    input  wire logic                   arbLost,    // Arbitration lost
    input  wire logic                   dmaAck,     // Controller did one op
    input  wire logic                   dmaCountZero, // Counter reached zero
    output vpw_dma_pkg::dma_req_s       dmaReq,     // Request to controller
    input  wire logic [7:0]             dmaWdata,   // Byte fetched by controller
    output logic [7:0]                  dmaRdata,   // Byte handed to controller
    output logic [7:0]                  txOpcode,   // Opcode to transmitter
    output logic [7:0]                  tx_byte_reg,     // Data byte to transmitter
    output logic                        txOpValid,  // Opcode with data ready
    output logic                        eobIrq      // End-of-block request
);
    import vpw_dma_pkg::*;

    // ********************************************
    // Register state
    // ********************************************
    logic [7:0] interrupt_mask_reg;
    logic [7:0] priority_level_reg;
    logic [7:0] options;
    logic [7:0] ptr [SUBPAGE_REGS];
    logic       rxFull;
    logic       txReady;
    logic       txDataLoaded;
    dma_state_e state;
    logic       rxReq;
    logic       txReq;
    logic       suspend;
    logic       inPage;
    logic       swWr;
    logic       swRd;
    logic       wrTxop;
    logic       wrTxdata;
    logic       rdRx;
    logic       opNeedsData;
    logic       lastOp;

    // Page decode; addresses below the block window are not ours
    assign inPage = (regPage == REG_PAGE) && (regReq.addr >= UNPAGED_FIRST);
    assign swWr   = regReq.wr & inPage;
    assign swRd   = regReq.rd & inPage;

    // Suspend only when the option is on; otherwise the flags are ignored
    assign suspend = options[OPT_SUSP] & (errorFlag | arbLost);

    // ********************************************
    // Request gates
    // ********************************************
    vpw_dma_request rxGate (
        .trigger (rxFull),
        .enable  (interrupt_mask_reg[IMR_RXD_EN]),
        .suspend (suspend),
        .request (rxReq)
    );

    vpw_dma_request txGate (
        .trigger (txReady),
        .enable  (interrupt_mask_reg[IMR_TXD_EN]),
        .suspend (suspend),
        .request (txReq)
    );

    // Opcode needs a data byte when any data-class bit is set
    assign opNeedsData = |(dmaWdata & OP_DATA_MASK);
    assign lastOp      = dmaAck & dmaCountZero;

    // ********************************************
    // DMA sequencer
    // ********************************************
    // One byte per receive request; opcode then optional data on transmit.
    // A wait for dmaAck of any length sits between the two transmit bytes.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    // Receive wins, matching the higher internal priority
                    if (rxReq) begin
                        state <= ST_RX;
                    end else if (txReq) begin
                        state <= ST_TX_OPCODE_REG;
                    end
                end
                ST_RX: begin
                    if (dmaAck) begin
                        state <= ST_IDLE;
                    end
                end
                ST_TX_OPCODE_REG: begin
                    if (dmaAck && opNeedsData && !dmaCountZero) begin
                        state <= ST_TX_BYTE_REG;
                    end else if (dmaAck) begin
                        state <= ST_IDLE;
                    end
                end
                ST_TX_BYTE_REG: begin
                    if (dmaAck) begin
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Request fields toward the controller; pointers chosen by direction
    always_comb begin
        dmaReq.isRx    = (state == ST_RX);
        dmaReq.req     = (state != ST_IDLE) && !suspend;
        dmaReq.addrPtr = dmaReq.isRx ? ptr[SUB_RX_ADDR_POINTER] : ptr[SUB_TX_ADDR_POINTER];
        dmaReq.cntPtr  = dmaReq.isRx ? ptr[SUB_RX_COUNT_POINTER] : ptr[SUB_TX_COUNT_POINTER];
        // Cleared select bit means memory; set means register file pair
        dmaReq.isMem   = ~dmaReq.cntPtr[CPR_RFMEM];
    end
    // The controller counts and steps the address per operation

    // ********************************************
    // Trigger flags
    // ********************************************
    // Buffer-full: set by a new byte, cleared by DMA read or software read
    assign rdRx = (state == ST_RX && dmaAck) || (swRd && regReq.addr == ADDR_RX_BYTE_REG);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxFull <= 1'b0;
        end else if (rxByteIn) begin
            rxFull <= 1'b1; // Set wins over a same-cycle clear
        end else if (rdRx) begin
            rxFull <= 1'b0;
        end
    end

    // Transmit-ready: cleared by an opcode write, set on acceptance, which wins in the same cycle
    assign wrTxop = (state == ST_TX_OPCODE_REG && dmaAck) || (swWr && regReq.addr == ADDR_TX_OPCODE_REG);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txReady <= 1'b1;
        end else if (txAccept) begin
            txReady <= 1'b1;
        end else if (wrTxop) begin
            txReady <= 1'b0;
        end
    end

    // ********************************************
    // Transmit byte registers
    // ********************************************
    assign wrTxdata = (state == ST_TX_BYTE_REG && dmaAck) || (swWr && regReq.addr == ADDR_TX_BYTE_REG);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txOpcode     <= RST_TX_OPCODE_REG;
            tx_byte_reg       <= RST_BYTE;
            txDataLoaded <= 1'b0;
            txOpValid    <= 1'b0;
        end else begin
            if (wrTxdata) begin
                tx_byte_reg       <= (state == ST_TX_BYTE_REG) ? dmaWdata : regReq.wdata;
                txDataLoaded <= 1'b1;
            end
            if (wrTxop) begin
                txOpcode <= (state == ST_TX_OPCODE_REG) ? dmaWdata : regReq.wdata;
            end
            // Without DMA the data byte must already be there
            if (txAccept) begin
                txOpValid    <= 1'b0;
                txDataLoaded <= 1'b0;
            end else if (wrTxop && state != ST_TX_OPCODE_REG
                         && (txDataLoaded || (regReq.wdata & OP_DATA_MASK) == 8'h00)) begin
                // Software opcode needing data is valid only if the data byte is already in
                txOpValid <= 1'b1;
            end else if (state == ST_TX_OPCODE_REG && dmaAck && !(opNeedsData && !dmaCountZero)) begin
                txOpValid <= 1'b1;
            end else if (state == ST_TX_BYTE_REG && dmaAck && interrupt_mask_reg[IMR_TXD_EN]) begin
                txOpValid <= 1'b1;
            end
        end
    end

    assign dmaRdata = rxByte;

    // ********************************************
    // Control registers and end of block
    // ********************************************
    // End of block sets pending and drops the matching enable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            interrupt_mask_reg  <= RST_IMR;
            priority_level_reg <= RST_PRIORITY_LEVEL_REG;
        end else begin
            if (swWr && regReq.addr == ADDR_IMR) begin
                interrupt_mask_reg <= regReq.wdata;
            end
            if (swWr && regReq.addr == ADDR_PRIORITY_LEVEL_REG) begin
                priority_level_reg <= regReq.wdata;
            end
            if (lastOp && state == ST_RX) begin
                priority_level_reg[PRIORITY_LEVEL_REG_RX_END_OF_BLOCK_PENDING]  <= 1'b1;
                interrupt_mask_reg[IMR_RXD_EN]   <= 1'b0;
            end
            if (lastOp && (state == ST_TX_OPCODE_REG || state == ST_TX_BYTE_REG)) begin
                priority_level_reg[PRIORITY_LEVEL_REG_TX_END_OF_BLOCK_PENDING]  <= 1'b1;
                interrupt_mask_reg[IMR_TXD_EN]   <= 1'b0;
            end
        end
    end

    // Options and the four subpage-0 pointers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            options <= RST_OPTIONS;
            for (int i = 0; i < SUBPAGE_REGS; i++) begin
                ptr[i] <= RST_PTR;
            end
        end else begin
            if (swWr && regReq.addr == ADDR_OPTIONS) begin
                options <= regReq.wdata;
            end
            // Subpage selected by the low nibble of options
            if (swWr && regReq.addr >= SUBPAGE_BASE && options[3:0] == 4'h0) begin
                ptr[regReq.addr[1:0]] <= regReq.wdata;
            end
        end
    end

    // Interrupt request masked by bits 5 and 6, at the buffer-full and transmit-ready status positions
    assign eobIrq = (priority_level_reg[PRIORITY_LEVEL_REG_RX_END_OF_BLOCK_PENDING] & interrupt_mask_reg[STATUS_RX_BUFFER_FULL_FLAG]) | (priority_level_reg[PRIORITY_LEVEL_REG_TX_END_OF_BLOCK_PENDING] & interrupt_mask_reg[STATUS_TX_READY_FLAG]);

    // ********************************************
    // Read port
    // ********************************************
    // Unimplemented addresses in the block window read as zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdata <= 8'h00;
        end else if (swRd) begin
            regRdata <= 8'h00;
            if (regReq.addr <= UNPAGED_LAST) begin
                unique case (regReq.addr)
                    ADDR_STATUS:  regRdata <= {errorFlag, txReady, rxFull, arbLost, 4'h0};
                    ADDR_TX_BYTE_REG:  regRdata <= tx_byte_reg;
                    ADDR_TX_OPCODE_REG:    regRdata <= txOpcode;
                    ADDR_RX_BYTE_REG:  regRdata <= rxByte;
                    ADDR_IMR:     regRdata <= interrupt_mask_reg;
                    ADDR_PRIORITY_LEVEL_REG:    regRdata <= priority_level_reg;
                    ADDR_OPTIONS: regRdata <= options;
                    default:      regRdata <= 8'h00;
                endcase
            end else if (options[3:0] == 4'h0) begin
                regRdata <= ptr[regReq.addr[1:0]];
            end
        end else begin
            regRdata <= 8'h00;
        end
    end

    // ********************************************
    // Checks
    // ********************************************
    rx_one_byte_a : assert property (@(posedge clk) disable iff (!rst_n)
        (state == ST_RX && dmaAck) |=> (state == ST_IDLE))
        else $error("receive cycle moved more than one byte");
    rx_flag_clear_a : assert property (@(posedge clk) disable iff (!rst_n)
        (state == ST_RX && dmaAck && !rxByteIn) |=> !rxFull)
        else $error("buffer-full flag not cleared after receive");
    rx_eob_a : assert property (@(posedge clk) disable iff (!rst_n)
        (state == ST_RX && lastOp) |=> (!interrupt_mask_reg[IMR_RXD_EN] && priority_level_reg[PRIORITY_LEVEL_REG_RX_END_OF_BLOCK_PENDING]))
        else $error("receive end of block not handled");
    tx_eob_a : assert property (@(posedge clk) disable iff (!rst_n)
        ((state == ST_TX_OPCODE_REG || state == ST_TX_BYTE_REG) && lastOp)
        |=> (!interrupt_mask_reg[IMR_TXD_EN] && priority_level_reg[PRIORITY_LEVEL_REG_TX_END_OF_BLOCK_PENDING]))
        else $error("transmit end of block not handled");
    tx_two_byte_a : assert property (@(posedge clk) disable iff (!rst_n)
        (state == ST_TX_OPCODE_REG && dmaAck && opNeedsData && !dmaCountZero) |=> (state == ST_TX_BYTE_REG))
        else $error("data byte skipped");
    tx_wait_data_a : assert property (@(posedge clk) disable iff (!rst_n)
        (state == ST_TX_BYTE_REG && !dmaAck) |=> (state == ST_TX_BYTE_REG))
        else $error("data wait abandoned");
    suspend_hold_a : assert property (@(posedge clk) disable iff (!rst_n)
        (options[OPT_SUSP] && (errorFlag || arbLost)) |-> !dmaReq.req)
        else $error("request while suspended");
    no_suspend_a : assert property (@(posedge clk) disable iff (!rst_n)
        (!options[OPT_SUSP] && state != ST_IDLE) |-> dmaReq.req)
        else $error("flags blocked dma without option");
    no_suspend_go_a : assert property (@(posedge clk) disable iff (!rst_n)
        (!options[OPT_SUSP] && state == ST_IDLE && rxFull && interrupt_mask_reg[IMR_RXD_EN])
        |=> (state == ST_RX))
        else $error("receive request not started without option");
endmodule
`default_nettype wire

// >>> design/vpw_dma_pkg.sv
// Package for the DMA interface of the VPW byte decoder.
// Assumes a single 50 MHz core clock and a one-cycle register port.
package vpw_dma_pkg;

    // ********************************************
    // Register page and addresses
    // ********************************************
    localparam logic [7:0] REG_PAGE        = 8'h17;
    localparam logic [7:0] UNPAGED_FIRST   = 8'hF0;
    localparam logic [7:0] UNPAGED_LAST    = 8'hFB;
    localparam logic [7:0] SUBPAGE_BASE    = 8'hFC;
    localparam int         SUBPAGE_COUNT   = 9;
    localparam int         SUBPAGE_REGS    = 4;
    localparam int         PAGE_REG_COUNT  = 48;
    localparam logic [7:0] RF_LIMIT        = 8'hDF;

    // Unpaged registers used by this block
    localparam logic [7:0] ADDR_STATUS     = 8'hF0;
    localparam logic [7:0] ADDR_TX_BYTE_REG     = 8'hF1;
    localparam logic [7:0] ADDR_TX_OPCODE_REG       = 8'hF2;
    localparam logic [7:0] ADDR_RX_BYTE_REG     = 8'hF3;
    localparam logic [7:0] ADDR_IMR        = 8'hF4;
    localparam logic [7:0] ADDR_PRIORITY_LEVEL_REG       = 8'hF5;
    localparam logic [7:0] ADDR_OPTIONS    = 8'hF6;
    // Subpage 0 holds the four DMA pointers
    localparam logic [1:0] SUB_RX_ADDR_POINTER       = 2'h0;
    localparam logic [1:0] SUB_RX_COUNT_POINTER       = 2'h1;
    localparam logic [1:0] SUB_TX_ADDR_POINTER       = 2'h2;
    localparam logic [1:0] SUB_TX_COUNT_POINTER       = 2'h3;

    // ********************************************
    // Field positions
    // ********************************************
    localparam int STATUS_ERR   = 7;
    localparam int STATUS_TX_READY_FLAG  = 6;
    localparam int STATUS_RX_BUFFER_FULL_FLAG  = 5;
    localparam int STATUS_TLA   = 4;
    localparam int IMR_RXD_EN   = 1;
    localparam int IMR_TXD_EN   = 0;
    localparam int PRIORITY_LEVEL_REG_RX_END_OF_BLOCK_PENDING   = 1;
    localparam int PRIORITY_LEVEL_REG_TX_END_OF_BLOCK_PENDING   = 0;
    localparam int OPT_SUSP     = 7;
    localparam int CPR_RFMEM    = 0;

    // ********************************************
    // Reset values
    // ********************************************
    localparam logic [7:0] RST_IMR     = 8'h00;
    localparam logic [7:0] RST_PRIORITY_LEVEL_REG    = 8'hE0;
    localparam logic [7:0] RST_OPTIONS = 8'h00;
    localparam logic [7:0] RST_PTR     = 8'h00;
    localparam logic [7:0] RST_TX_OPCODE_REG    = 8'h00;
    localparam logic [7:0] RST_BYTE    = 8'h00;

    // Opcode codes 0 and 1 need no data byte in this model
    localparam logic [7:0] OP_DATA_MASK = 8'h06;

    // ********************************************
    // Types
    // ********************************************
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic        req;
        logic        isMem;
        logic        isRx;
        logic [7:0]  addrPtr;
        logic [7:0]  cntPtr;
    } dma_req_s;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_RX     = 2'b01,
        ST_TX_OPCODE_REG   = 2'b10,
        ST_TX_BYTE_REG = 2'b11
    } dma_state_e;

endpackage

// >>> design/vpw_dma_request.sv
// Request gate for one DMA direction.
// Assumes trigger, enable and suspend come from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module vpw_dma_request (
    input  wire logic trigger,    // Hardware flag that asks for service
    input  wire logic enable,     // Direction DMA enable bit
    input  wire logic suspend,    // Suspend condition is present
    output logic      request     // Gated request to the controller
);
    // Drop while suspended, return when suspend clears and flag still set
    assign request = trigger & enable & ~suspend;
endmodule
`default_nettype wire

// >>> test/dma_ctrl_model.sv
// Behavioural model of the on-chip DMA controller beside the block.
// Assumes one clock; the bench loads tbl, remaining and delay directly.
`timescale 1ns/1ps
`default_nettype none
module dma_ctrl_model (
    input  wire logic                  clk,          // Core clock
    input  wire logic                  rst_n,        // Async reset, active low
    input  wire vpw_dma_pkg::dma_req_s dmaReq,       // Request from the block
    input  wire logic [7:0]            dmaRdata,     // Received byte
    output logic                       dmaAck,       // One operation done
    output logic                       dmaCountZero, // Counter reached zero
    output logic [7:0]                 dmaWdata      // Fetched table byte
);
    import vpw_dma_pkg::*;
    // ****************************************
    // Transfer engine
    // ****************************************
    logic [7:0] tbl[$];        // Opcodes, each with data only if needed
    logic [7:0] got[$];        // Bytes stored by receive transfers
    int         remaining = 0; // Transaction counter
    int         delay     = 0; // Grant latency, stands in for a busy bus
    int         waited    = 0;
    int         acks      = 0;
    dma_req_s   lastReq;       // Request fields seen at the last grant

    // One operation per grant; lines churn between grants so stale data never passes
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dmaAck       <= 1'b0;
            dmaCountZero <= 1'b0;
            dmaWdata     <= 8'h00;
            waited       <= 0;
        end else begin
            dmaAck       <= 1'b0;
            dmaWdata     <= ~dmaWdata;
            dmaCountZero <= ~dmaCountZero;
            if (!dmaReq.req || dmaAck) begin
                waited <= 0;
            end else if (waited < delay) begin
                waited <= waited + 1;                  // Late grant
            end else begin
                waited       <= 0;
                dmaAck       <= 1'b1;
                lastReq      <= dmaReq;                // Pointer pair choice
                acks         <= acks + 1;
                remaining    <= remaining - 1;         // Post-decrement
                dmaCountZero <= (remaining == 1);      // Last transfer
                if (dmaReq.isRx) begin
                    got.push_back(dmaRdata);           // One byte a grant
                end else begin
                    dmaWdata <= tbl.pop_front();       // Next table location
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> test/vpw_decoder_dma_interface_test.sv
// Self-checking bench for the DMA interface of the VPW byte decoder.
// Assumes dma_ctrl_model stands at the far side; clock is 50 MHz.
`timescale 1ns/1ps
`default_nettype none
module vpw_decoder_dma_interface_test;
    import vpw_dma_pkg::*;
    logic       clk = 1'b0, rst_n = 1'b0, rxByteIn = 1'b0, txAccept = 1'b0;
    logic       errorFlag = 1'b0, arbLost = 1'b0, dmaAck, dmaCountZero, txOpValid, eobIrq;
    logic [7:0] regPage = REG_PAGE, rxByte = 8'h00, regRdata, dmaWdata, dmaRdata;
    logic [7:0] txOpcode, tx_byte_reg, b;
    logic [7:0] ops[3] = '{8'h02, 8'h00, 8'h06};
    logic [7:0] dat[3];
    reg_req_s   regReq = '0;
    dma_req_s   dmaReq;
    int         err_count = 0, num_checks = 0, seed = 32'hf44d, k, n;

    // ****************************************
    // Clock, design and far side
    // ****************************************
    always #10 clk = ~clk;
    vpw_byte_decoder_dma DUT (
        .clk(clk), .rst_n(rst_n), .regPage(regPage), .regReq(regReq), .regRdata(regRdata),
        .rxByteIn(rxByteIn), .rxByte(rxByte), .txAccept(txAccept), .errorFlag(errorFlag),
        .arbLost(arbLost), .dmaAck(dmaAck), .dmaCountZero(dmaCountZero), .dmaReq(dmaReq),
        .dmaWdata(dmaWdata), .dmaRdata(dmaRdata), .txOpcode(txOpcode), .tx_byte_reg(tx_byte_reg),
        .txOpValid(txOpValid), .eobIrq(eobIrq));
    dma_ctrl_model u_ctrl (
        .clk(clk), .rst_n(rst_n), .dmaReq(dmaReq), .dmaRdata(dmaRdata), .dmaAck(dmaAck),
        .dmaCountZero(dmaCountZero), .dmaWdata(dmaWdata));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("Checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Write strobe for one cycle
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        regReq <= '0;
        #1; // Let the write settle before any compare
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        regReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        regReq <= '0;
        #1;
        check($sformatf("reg %h", a), regRdata, exp);
    endtask
    task automatic rx_pulse(input logic [7:0] v);
        @(posedge clk);
        rxByteIn <= 1'b1;
        rxByte   <= v;
        @(posedge clk);
        rxByteIn <= 1'b0;
    endtask
    task automatic wait_acks(input int want);
        for (int i = 0; i < 200 && u_ctrl.acks < want; i++) @(posedge clk);
        #1;
        check("grant count", 8'(u_ctrl.acks), 8'(want));
    endtask
    // Opcodes with bit 1 or 2 set carry a data byte
    function automatic int op_len(input logic [7:0] op);
        return ((op & OP_DATA_MASK) != 8'h00) ? 2 : 1;
    endfunction

    // Hang guard, far above the few hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        print_verdict();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        reg_rd(ADDR_IMR, 8'h00);
        reg_rd(ADDR_PRIORITY_LEVEL_REG, 8'hE0);
        reg_rd(ADDR_OPTIONS, 8'h00);
        reg_rd(ADDR_STATUS, 8'h40);
        reg_rd(8'hE0, 8'h00);
        regPage <= 8'h16;
        reg_rd(ADDR_PRIORITY_LEVEL_REG, 8'h00);
        regPage <= REG_PAGE;
        reg_wr(SUBPAGE_BASE, 8'h40);
        reg_wr(SUBPAGE_BASE + 8'h01, 8'h31);
        reg_wr(ADDR_OPTIONS, 8'h01);
        reg_rd(SUBPAGE_BASE, 8'h00);
        reg_wr(ADDR_OPTIONS, 8'h00);
        reg_rd(SUBPAGE_BASE, 8'h40);
        // Receive block of three bytes in register file mode
        u_ctrl.remaining = 3;
        reg_wr(ADDR_IMR, 8'h02);
        for (k = 0; k < 3; k++) begin
            b = 8'($random(seed));
            u_ctrl.delay = $unsigned($random(seed)) % 4;
            rx_pulse(b);
            wait_acks(k + 1);
            check("rx byte", u_ctrl.got[k], b);
            check("rx kind", {6'h00, u_ctrl.lastReq.isRx, u_ctrl.lastReq.isMem}, 8'h02);
        end
        reg_rd(ADDR_IMR, 8'h00);
        reg_rd(ADDR_PRIORITY_LEVEL_REG, 8'hE2);
        reg_rd(ADDR_STATUS, 8'h40);
        check("eob irq", {7'h00, eobIrq}, 8'h00);
        reg_wr(ADDR_IMR, 8'h20);
        check("eob irq", {7'h00, eobIrq}, 8'h01);
        reg_wr(ADDR_PRIORITY_LEVEL_REG, 8'hE0);
        check("eob irq", {7'h00, eobIrq}, 8'h00);
        // Suspend by error, then by lost arbitration, then flags ignored
        u_ctrl.remaining = 100;
        reg_wr(ADDR_IMR, 8'h02);
        reg_wr(ADDR_OPTIONS, 8'h80);
        for (k = 0; k < 3; k++) begin
            b = 8'($random(seed));
            if (k == 2) reg_wr(ADDR_OPTIONS, 8'h00);
            @(posedge clk);
            errorFlag <= (k != 1);
            arbLost   <= (k == 1);
            rx_pulse(b);
            if (k < 2) begin
                repeat (20) @(posedge clk);
                #1;
                check("held req", {7'h00, dmaReq.req}, 8'h00);
                reg_rd(ADDR_STATUS, (k == 0) ? 8'hE0 : 8'h70);
                @(posedge clk);
                errorFlag <= 1'b0;
                arbLost   <= 1'b0;
            end
            wait_acks(4 + k);
            check("rx byte", u_ctrl.got[3 + k], b);
        end
        @(posedge clk);
        errorFlag <= 1'b0;
        reg_wr(ADDR_IMR, 8'h00);
        // Transmit table from memory, slow grants between opcode and data
        n = 0;
        for (k = 0; k < 3; k++) begin
            dat[k] = 8'($random(seed));
            u_ctrl.tbl.push_back(ops[k]);
            if (op_len(ops[k]) == 2) u_ctrl.tbl.push_back(dat[k]);
            n += op_len(ops[k]);
        end
        u_ctrl.remaining = n;
        u_ctrl.delay = 6;
        reg_wr(8'hFE, 8'h44);
        reg_wr(8'hFF, 8'h20);
        reg_wr(ADDR_IMR, 8'h01);
        n = u_ctrl.acks;
        for (k = 0; k < 3; k++) begin
            n += op_len(ops[k]);
            wait_acks(n);
            for (int i = 0; i < 50 && txOpValid !== 1'b1; i++) @(posedge clk);
            check("tx valid", {7'h00, txOpValid}, 8'h01);
            check("tx opcode", txOpcode, ops[k]);
            if (op_len(ops[k]) == 2) check("tx data", tx_byte_reg, dat[k]);
            check("tx addr ptr", u_ctrl.lastReq.addrPtr, 8'h44);
            check("tx cnt ptr", u_ctrl.lastReq.cntPtr, 8'h20);
            check("tx kind", {6'h00, u_ctrl.lastReq.isRx, u_ctrl.lastReq.isMem}, 8'h01);
            reg_rd(ADDR_STATUS, 8'h00);
            @(posedge clk);
            txAccept <= 1'b1;
            @(posedge clk);
            txAccept <= 1'b0;
        end
        reg_rd(ADDR_IMR, 8'h00);
        reg_rd(ADDR_PRIORITY_LEVEL_REG, 8'hE1);
        check("tx req", {7'h00, dmaReq.req}, 8'h00);
        // Software transmit without DMA: the data byte has to come first
        reg_wr(ADDR_TX_OPCODE_REG, 8'h02);
        check("sw op valid", {7'h00, txOpValid}, 8'h00);
        reg_wr(ADDR_TX_BYTE_REG, 8'h5A);
        reg_wr(ADDR_TX_OPCODE_REG, 8'h02);
        check("sw op valid", {7'h00, txOpValid}, 8'h01);
        reg_rd(ADDR_TX_BYTE_REG, 8'h5A);
        print_verdict();
    end
endmodule
`default_nettype wire
